// ### clock_select_pkg.sv
// Constants for the system clock selection block.
// Assumes an 8-bit register port with a 16-bit address.
package clock_select_pkg;
  // Register byte addresses
  localparam logic [15:0] PCC_ADDR   = 16'hFFFB;
  localparam logic [15:0] OSCILLATION_MODE_REG_ADDR  = 16'hFFF2;
  localparam logic [15:0] PSEL_ADDR  = 16'hFF42;
  localparam logic [15:0] PREA_ADDR  = 16'hFF70;
  localparam logic [15:0] PREB_ADDR  = 16'hFF71;
  // Reset values
  localparam logic [7:0]  PCC_RESET  = 8'h04;
  localparam logic [7:0]  OSCILLATION_MODE_REG_RESET = 8'h00;
  localparam logic [7:0]  PSEL_RESET = 8'h00;
  // Processor clock control field positions
  localparam int PCC_MCC_BIT = 7;
  localparam int PCC_FRC_BIT = 6;
  localparam int PCC_CLS_BIT = 5;
  localparam int PCC_CSS_BIT = 4;
  localparam int PCC_DIV_LSB = 0;
  // Peripheral clock select field positions
  localparam int PSEL_WD_LSB  = 0;
  localparam int PSEL_WT_BIT  = 4;
  localparam int PSEL_BZ_LSB  = 5;
  // Divider figures
  localparam logic [2:0] CPU_DIV_MAX  = 3'h4;
  localparam logic [3:0] WD_BASE_EXP  = 4'h3;
  localparam logic [3:0] WD_TOP_EXP   = 4'hB;
  localparam logic [3:0] WT_EXP       = 4'h7;
  localparam logic [3:0] BZ_BASE_EXP  = 4'h9;
  localparam int         CHAIN_W      = 12;
  localparam int         CPU_CNT_W    = 5;
  // Pre-divider phase counts
  localparam logic [3:0] PH_MOD3      = 4'h3;
  localparam logic [3:0] PH_MOD9      = 4'h9;
  localparam logic [3:0] PH_SECOND9   = 4'h4;
endpackage : clock_select_pkg

// ### tick_counter.sv
// Free-running tick counter used as a binary prescaler chain.
// Assumes inc_i and clr_i come from logic on the same clock.
`timescale 1ns/1ps
module tick_counter #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  input  wire logic         ce_i,
  // Control
  input  wire logic         inc_i,
  input  wire logic         clr_i,
  output logic      [W-1:0] count_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_s;

  cnt_state_s r, nxt;

  // Clear wins so a switched divider starts from a clean phase
  always_comb begin
    nxt = r;
    if (clr_i) begin
      nxt.cnt = '0;
    end else if (inc_i) begin
      nxt.cnt = r.cnt + 1'b1;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= nxt;
    end
  end

  assign count_o = r.cnt;
endmodule : tick_counter

// ### system_clock_select.sv
// System clock generation and selection: main clock, CPU prescaler,
// watchdog, watch timer and buzzer clock selects, as clock-enable ticks and a buzzer square-wave level.
// Assumes oscillator pins are asynchronous and far slower than mclk_i.
//
// How it works
// RQ1: Oscillation mode write stretches fxx up to 2/fx
// RQ2: Bypass change affects peripheral and CPU clocks
// RQ3: Software writes oscillation mode once after reset
// RQ4: No-halving variant forbids clearing bypass bit
// RQ5: Instruction tick every two CPU clocks
// RQ6: CPU clock fx/1..32 or subsystem clock
// RQ7: Pre-dividers give fx, 2fx/3, fx/3, 2fx/9
// RQ8: Subsystem CPU clock is subsystem frequency halved
// RQ9: Reset loads 04H and 00H
// RQ10: Software writes 00H/01H for fastest clock
// RQ11: Subsystem CPU clock enters low current mode
// RQ12: fxx is fx with bypass, fx/2 without
// RQ13: Watchdog clock fxx/2^3..2^9, code 7 2^11
// RQ14: Watch clock fxx/2^7 or subsystem clock
// RQ15: Buzzer off, fxx/2^9..2^11, 111 prohibited
// RQ16: Software stops timer before changing peripheral select
// RQ17: Control register bit layout as documented
// RQ18: Clock status bit shows source, ignores writes
// RQ19: Clock switches only at a safe boundary
// RQ20: Prohibited codes keep the previous selection
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module system_clock_select
  import clock_select_pkg::*;
#(
  parameter bit HAS_DIV2   = 1'b1,
  parameter bit HAS_SUBSYS = 1'b1,
  parameter bit HAS_PREDIV = 1'b1
) (
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  // Oscillator pins
  input  wire logic        main_osc_pin_i,
  input  wire logic        sub_osc_pin_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // Clock ticks and levels
  output logic             fxx_tick_o,
  output logic             cpu_tick_o,
  output logic             instr_tick_o,
  output logic             wdog_tick_o,
  output logic             watch_tick_o,
  output logic             buzzer_o,
  // Oscillator controls and status
  output logic             main_osc_stop_o,
  output logic             feedback_resistor_select_o,
  output logic             low_power_o
);
  import clock_select_pkg::*;

  typedef struct packed {
    logic       fx_s1, fx_s2, fx_s3;
    logic       xt_s1, xt_s2, xt_s3;
    logic       main_osc_stop;
    logic       feedback_resistor_select;
    logic       css;
    logic [2:0] cpu_divider_field;
    logic       main_divider_bypass;
    logic       predivider_bit_a;
    logic       predivider_bit_b;
    logic [7:0] psel;
    logic [3:0] pre_ph;
    logic       half;
    logic       stretch;
    logic       xt_half;
    logic       css_act;
    logic [2:0] div_act;
    logic       cpu_clock_status;
    logic       instr_ph;
    logic       fxx_tick;
    logic       cpu_tick;
    logic       instr_tick;
    logic       wdog_tick;
    logic       watch_tick;
    logic       buzzer;
    logic [7:0] rdata;
  } state_s;

  state_s r, nxt;
  logic [CHAIN_W-1:0]   chain_cnt;
  logic [CPU_CNT_W-1:0] cpu_cnt;
  logic                 cpu_src_tick;
  logic                 cpu_now;

  // True when the low k bits of c are all ones
  function automatic logic low_ones(input logic [CHAIN_W-1:0] c, input logic [3:0] k);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < CHAIN_W; i++) begin
      if ((4'(i) < k) && !c[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : low_ones

  // Shared fxx prescaler for the watchdog, watch timer and buzzer taps; the CPU has its own prescaler
  tick_counter #(.W(CHAIN_W)) u_chain (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .inc_i     (r.fxx_tick),
    .clr_i     (1'b0),
    .count_o   (chain_cnt)
  );

  // CPU prescaler, restarted at every CPU tick, which is also where a new selection takes over
  tick_counter #(.W(CPU_CNT_W)) u_cpu (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .inc_i     (cpu_src_tick),
    .clr_i     (cpu_now),
    .count_o   (cpu_cnt)
  );

  // Source tick and CPU tick decision, shared with the state update
  always_comb begin
    cpu_src_tick = r.css_act ? (r.xt_s2 && !r.xt_s3 && r.xt_half) : r.fxx_tick; // [RQ8]
    cpu_now      = cpu_src_tick &&
                   low_ones(CHAIN_W'(cpu_cnt), r.css_act ? 4'h0 : {1'b0, r.div_act}); // [RQ6]
  end

  // Next-state logic for the whole block
  always_comb begin
    logic       fx_edge;
    logic       xt_edge;
    logic       pre_hit;
    logic       raw;
    logic [3:0] ph_mod;
    logic [3:0] wd_exp;
    logic [3:0] bz_exp;
    logic       legal;
    fx_edge = 1'b0;
    xt_edge = 1'b0;
    pre_hit = 1'b0;
    raw     = 1'b0;
    ph_mod  = 4'h1;
    wd_exp  = 4'h0;
    bz_exp  = 4'h0;
    legal   = 1'b0;
    nxt     = r;

    // Pin synchronisers; only the second and third stages feed logic
    nxt.fx_s1 = main_osc_pin_i;
    nxt.fx_s2 = r.fx_s1;
    nxt.fx_s3 = r.fx_s2;
    nxt.xt_s1 = sub_osc_pin_i;
    nxt.xt_s2 = r.xt_s1;
    nxt.xt_s3 = r.xt_s2;
    fx_edge   = r.fx_s2 && !r.fx_s3 && !r.main_osc_stop;
    xt_edge   = r.xt_s2 && !r.xt_s3;

    // Fractional pre-divider pattern on fx edges
    case ({r.predivider_bit_b, r.predivider_bit_a} & {2{HAS_PREDIV}})
      2'b01:   begin ph_mod = PH_MOD3; pre_hit = (r.pre_ph != 4'h2); end // [RQ7]
      2'b10:   begin ph_mod = PH_MOD3; pre_hit = (r.pre_ph == 4'h0); end // [RQ7]
      2'b11:   begin ph_mod = PH_MOD9; pre_hit = (r.pre_ph == 4'h0) || (r.pre_ph == PH_SECOND9); end // [RQ7]
      default: begin ph_mod = 4'h1; pre_hit = 1'b1; end
    endcase
    if (fx_edge) begin
      nxt.pre_ph = (r.pre_ph + 4'h1 >= ph_mod) ? 4'h0 : r.pre_ph + 4'h1;
    end

    // Halving stage, bypassed when the bypass bit is set
    raw = fx_edge && pre_hit;
    if (raw && !r.main_divider_bypass) begin
      nxt.half = !r.half;
    end
    nxt.fxx_tick = raw && (r.main_divider_bypass || r.half) && !r.stretch; // [RQ12] [RQ2]
    // A pending mode write blocks any fxx tick on the next fx edge only, so at most one tick is swallowed
    if (fx_edge) begin
      nxt.stretch = 1'b0; // [RQ1]
    end

    // Subsystem clock halved for the CPU
    if (xt_edge) begin
      nxt.xt_half = !r.xt_half;
    end

    // New CPU source and divider take over only at a CPU tick
    nxt.cpu_tick = cpu_now;
    if (cpu_now) begin
      nxt.css_act          = r.css; // [RQ19]
      nxt.div_act          = r.cpu_divider_field; // [RQ19]
      nxt.cpu_clock_status = r.css; // [RQ18] [RQ11]
      nxt.instr_ph         = !r.instr_ph;
    end
    nxt.instr_tick = cpu_now && r.instr_ph; // [RQ5]

    // Watchdog count clock tap
    wd_exp = (r.psel[2:0] == 3'h7) ? WD_TOP_EXP : WD_BASE_EXP + {1'b0, r.psel[2:0]};
    nxt.wdog_tick = r.fxx_tick && low_ones(chain_cnt, wd_exp); // [RQ13]

    // Watch timer clock: chain tap or raw subsystem clock
    nxt.watch_tick = r.psel[PSEL_WT_BIT] ? xt_edge : (r.fxx_tick && low_ones(chain_cnt, WT_EXP)); // [RQ14]

    // Buzzer square wave from the chain bit one below the divide figure
    bz_exp     = BZ_BASE_EXP + {2'h0, r.psel[6:5]};
    nxt.buzzer = r.psel[7] && chain_cnt[bz_exp - 4'h1]; // [RQ15]

    // Register writes
    if (wr_i) begin
      case (addr_i)
        PCC_ADDR: begin
          nxt.main_osc_stop            = wdata_i[PCC_MCC_BIT];
          nxt.feedback_resistor_select = wdata_i[PCC_FRC_BIT];
          legal = wdata_i[PCC_CSS_BIT] ? (HAS_SUBSYS && wdata_i[2:0] == 3'h0)
                                       : (wdata_i[2:0] <= CPU_DIV_MAX); // [RQ8] [RQ6]
          if (legal) begin
            nxt.css               = wdata_i[PCC_CSS_BIT];
            nxt.cpu_divider_field = wdata_i[PCC_DIV_LSB +: 3]; // [RQ20]
          end
        end
        OSCILLATION_MODE_REG_ADDR: begin
          nxt.stretch = 1'b1; // [RQ1]
          if (HAS_DIV2 || wdata_i[0]) begin
            nxt.main_divider_bypass = wdata_i[0]; // [RQ4]
          end
        end
        PSEL_ADDR: begin
          nxt.psel[2:0]         = wdata_i[PSEL_WD_LSB +: 3];
          nxt.psel[PSEL_WT_BIT] = wdata_i[PSEL_WT_BIT];
          if (wdata_i[7:5] != 3'h7) begin
            nxt.psel[7:5] = wdata_i[PSEL_BZ_LSB +: 3]; // [RQ20] [RQ15]
          end
        end
        PREA_ADDR: nxt.predivider_bit_a = wdata_i[0] && HAS_PREDIV;
        PREB_ADDR: nxt.predivider_bit_b = wdata_i[0] && HAS_PREDIV;
        default:   nxt.stretch = r.stretch && !fx_edge;
      endcase
    end

    // Read data stand one cycle after the strobe and only then
    nxt.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        PCC_ADDR:  nxt.rdata = {r.main_osc_stop, r.feedback_resistor_select, r.cpu_clock_status,
                                r.css, 1'b0, r.cpu_divider_field}; // [RQ17]
        PSEL_ADDR: nxt.rdata = r.psel;
        PREA_ADDR: nxt.rdata = {7'h00, r.predivider_bit_a};
        PREB_ADDR: nxt.rdata = {7'h00, r.predivider_bit_b};
        default:   nxt.rdata = 8'h00; // Write-only mode register and unmapped
      endcase
    end
  end

  // State register; reset picks the slowest main-clock CPU setting
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r                          <= '0;
      r.main_osc_stop            <= PCC_RESET[PCC_MCC_BIT];
      r.feedback_resistor_select <= PCC_RESET[PCC_FRC_BIT];
      r.css                      <= PCC_RESET[PCC_CSS_BIT];
      r.cpu_divider_field        <= PCC_RESET[2:0]; // [RQ9]
      r.div_act                  <= PCC_RESET[2:0];
      r.main_divider_bypass      <= OSCILLATION_MODE_REG_RESET[0]; // [RQ9] [RQ4]
      r.psel                     <= PSEL_RESET;
    end else if (ce_i) begin
      r <= nxt;
    end
  end

  // Outputs straight from the state register
  assign rdata_o                    = r.rdata;
  assign fxx_tick_o                 = r.fxx_tick;
  assign cpu_tick_o                 = r.cpu_tick;
  assign instr_tick_o               = r.instr_tick;
  assign wdog_tick_o                = r.wdog_tick;
  assign watch_tick_o               = r.watch_tick;
  assign buzzer_o                   = r.buzzer;
  assign main_osc_stop_o            = r.main_osc_stop;
  assign feedback_resistor_select_o = r.feedback_resistor_select;
  assign low_power_o                = r.cpu_clock_status;

  // Checks
  property p_stretch;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (ce_i && r.stretch && r.fx_s2 && !r.fx_s3) |=> !r.fxx_tick;
  endproperty
  a_stretch: assert property (p_stretch) else $error("fxx tick not suppressed after mode write"); // [RQ1]

  property p_bypass_full;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (ce_i && r.main_divider_bypass && !r.predivider_bit_a && !r.predivider_bit_b && !r.stretch
     && !r.main_osc_stop && r.fx_s2 && !r.fx_s3) |=> r.fxx_tick;
  endproperty
  a_bypass_full: assert property (p_bypass_full) else $error("fxx does not follow fx with bypass"); // [RQ12]

  property p_legal_div;
    @(posedge mclk_i) disable iff (!reset_n_i)
    r.css ? (r.cpu_divider_field == 3'h0) : (r.cpu_divider_field <= CPU_DIV_MAX);
  endproperty
  a_legal_div: assert property (p_legal_div) else $error("prohibited CPU divider accepted"); // [RQ20]

  property p_safe_switch;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ($changed(r.div_act) || $changed(r.css_act)) |-> r.cpu_tick;
  endproperty
  a_safe_switch: assert property (p_safe_switch) else $error("CPU divider switched between ticks"); // [RQ19]

  property p_status_write;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (ce_i && wr_i && addr_i == PCC_ADDR && !cpu_now) |=> $stable(r.cpu_clock_status);
  endproperty
  a_status_write: assert property (p_status_write) else $error("status bit moved on a write"); // [RQ18]

  property p_instr;
    @(posedge mclk_i) disable iff (!reset_n_i)
    instr_tick_o |-> cpu_tick_o;
  endproperty
  a_instr: assert property (p_instr) else $error("instruction tick without CPU tick"); // [RQ5]

  property p_buzz_off;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (ce_i && !r.psel[7]) |=> !buzzer_o;
  endproperty
  a_buzz_off: assert property (p_buzz_off) else $error("buzzer active while disabled"); // [RQ15]

  property p_watch_sub;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (ce_i && r.psel[PSEL_WT_BIT] && r.xt_s2 && !r.xt_s3) |=> watch_tick_o;
  endproperty
  a_watch_sub: assert property (p_watch_sub) else $error("watch tick missed subsystem edge"); // [RQ14]

  property p_wdog_base;
    @(posedge mclk_i) disable iff (!reset_n_i)
    wdog_tick_o |-> $past(r.fxx_tick);
  endproperty
  a_wdog_base: assert property (p_wdog_base) else $error("watchdog tick without fxx tick"); // [RQ13]

  c_sub_switch: cover property (@(posedge mclk_i) disable iff (!reset_n_i) $rose(low_power_o));
  c_buzz:       cover property (@(posedge mclk_i) disable iff (!reset_n_i) $rose(buzzer_o));
  c_fast:       cover property (@(posedge mclk_i) disable iff (!reset_n_i)
                                r.div_act == 3'h0 && r.main_divider_bypass && cpu_tick_o);
endmodule : system_clock_select

// ### system_clock_select_tb_top.sv
// Self-checking bench for the system clock selection block.
// Assumes the design defaults (halving, subsystem and pre-dividers present).
`timescale 1ns/1ps
module system_clock_select_tb_top;
  import clock_select_pkg::*;
  logic        mclk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1;
  logic        main_osc_pin_i = 1'b0, sub_osc_pin_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wdata_i = 8'h00, rdata_o, pcc_m, sel_m;
  logic        fxx_tick_o, cpu_tick_o, instr_tick_o, wdog_tick_o, watch_tick_o, buzzer_o;
  logic        main_osc_stop_o, feedback_resistor_select_o, low_power_o, buz_q;
  logic [31:0] rs = 32'h3353AE64;
  int          mismatches = 0, checks = 0, cyc = 0, fc = 0, sc = 0, nf, nc, n;
  int          tbl[4] = '{36, 24, 12, 8};

  system_clock_select #(.HAS_DIV2(1'b1), .HAS_SUBSYS(1'b1), .HAS_PREDIV(1'b1)) system_clock_select_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .main_osc_pin_i(main_osc_pin_i),
    .sub_osc_pin_i(sub_osc_pin_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .fxx_tick_o(fxx_tick_o), .cpu_tick_o(cpu_tick_o), .instr_tick_o(instr_tick_o),
    .wdog_tick_o(wdog_tick_o), .watch_tick_o(watch_tick_o), .buzzer_o(buzzer_o),
    .main_osc_stop_o(main_osc_stop_o), .feedback_resistor_select_o(feedback_resistor_select_o),
    .low_power_o(low_power_o));

  // 125 MHz system clock
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  // Oscillators locked to mclk so every interval is exact: fx 3+3, fxt 10+10
  always @(posedge mclk_i) begin
    fc = (fc == 5) ? 0 : fc + 1;
    sc = (sc == 19) ? 0 : sc + 1;
    main_osc_pin_i <= (fc < 3);
    sub_osc_pin_i  <= (sc < 10);
  end

  // Hang guard, above the roughly 60k cycles the sequence needs
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 95000) begin
      mismatches++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  // Event selector for interval measurements
  function automatic logic ev(input int s);
    case (s)
      0: return cpu_tick_o === 1'b1;
      1: return instr_tick_o === 1'b1;
      2: return wdog_tick_o === 1'b1;
      3: return watch_tick_o === 1'b1;
      default: return buzzer_o !== buz_q;
    endcase
  endfunction : ev

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen %0h expected %0h", $time, s, e);
    end
  endtask : chk

  // One cycle, sampled once the edge's updates have landed
  task step;
    buz_q = buzzer_o;
    @(posedge mclk_i);
    #1;
  endtask : step

  // Register write; the model keeps prohibited fields at their old value
  task wr(input logic [15:0] a, input logic [7:0] d);
    logic ok;
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
    ok = d[4] ? (d[2:0] == 3'h0) : (d[2:0] <= CPU_DIV_MAX);
    if (a == PCC_ADDR) pcc_m = {d[7:6], 1'b0, ok ? d[4] : pcc_m[4], 1'b0, ok ? d[2:0] : pcc_m[2:0]};
    if (a == PSEL_ADDR) sel_m = {(d[7:5] == 3'h7) ? sel_m[7:5] : d[7:5], d[4], 1'b0, d[2:0]};
  endtask : wr

  // Read: data stands in the following cycle only
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
    step();
    chk(rdata_o, 8'h00);
  endtask : rd

  // Main clock ticks and cycles between two consecutive events
  task gap(input int s, output int f, output int c);
    int t;
    t = 0;
    f = 0;
    c = 0;
    step();
    while (!ev(s) && t < 20000) begin
      step();
      t++;
    end
    do begin
      step();
      c++;
      if (fxx_tick_o === 1'b1) f++;
    end while (!ev(s) && c < 20000);
  endtask : gap

  task cnt(input int k, output int f);
    f = 0;
    repeat (k) begin
      step();
      if (fxx_tick_o === 1'b1) f++;
    end
  endtask : cnt

  task give_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  initial begin
    pcc_m = PCC_RESET;
    sel_m = PSEL_RESET;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    step();
    // Reset state, write-only and unmapped places
    rd(PCC_ADDR, 8'h04);
    rd(OSCILLATION_MODE_REG_ADDR, 8'h00);
    rd(PSEL_ADDR, 8'h00);
    rd(16'hFF00, 8'h00);
    cnt(216, n);
    chk(n, 18);
    gap(0, nf, nc);
    chk(nf, 16);
    // Status bit ignores writes, prohibited divider kept
    wr(PCC_ADDR, 8'hFF);
    repeat (3) step();
    rd(PCC_ADDR, 8'hC4);
    chk({main_osc_stop_o, feedback_resistor_select_o}, 2'b11);
    wr(PCC_ADDR, 8'h00);
    wr(PCC_ADDR, 8'h11);
    rd(PCC_ADDR, 8'h00);
    // Bypass and pre-divider combinations over 36 fx periods
    for (int b = 0; b < 2; b++) begin
      for (int p = 0; p < 4; p++) begin
        wr(OSCILLATION_MODE_REG_ADDR, b[7:0]);
        wr(PREA_ADDR, {7'h00, p[0]});
        wr(PREB_ADDR, {7'h00, p[1]});
        repeat (20) step();
        cnt(216, n);
        chk(n, tbl[p] >> (1 - b));
        if (p == 0) begin
          gap(2, nf, nc);
          chk(nc, 48 * (2 - b));
        end
      end
    end
    wr(PREA_ADDR, 8'h00);
    wr(PREB_ADDR, 8'h00);
    repeat (20) step();
    // Rewriting the same mode value swallows one tick
    wr(OSCILLATION_MODE_REG_ADDR, 8'h01);
    cnt(216, n);
    chk(n, 35);
    // CPU divider codes and instruction time
    for (int d = 0; d < 5; d++) begin
      wr(PCC_ADDR, d[7:0]);
      gap(0, nf, nc);
      gap(0, nf, nc);
      chk(nf, 1 << d);
      gap(1, nf, nc);
      chk(nf, 2 << d);
    end
    // Watchdog count clock codes; no dependent timer runs in the bench
    for (int c = 0; c < 8; c++) begin
      wr(PSEL_ADDR, c[7:0]);
      repeat (3) step();
      gap(2, nf, nc);
      chk(nf, 1 << ((c == 7) ? 11 : c + 3));
    end
    // Buzzer codes: half period is half the divider
    for (int c = 4; c < 7; c++) begin
      wr(PSEL_ADDR, {c[2:0], 5'h00});
      repeat (3) step();
      gap(4, nf, nc);
      chk(nf, 1 << (c + 4));
    end
    wr(PSEL_ADDR, 8'hE0);
    rd(PSEL_ADDR, 8'hC0);
    wr(PSEL_ADDR, 8'h00);
    repeat (4) step();
    chk(buzzer_o, 1'b0);
    // Watch clock sources
    gap(3, nf, nc);
    chk(nf, 128);
    wr(PSEL_ADDR, 8'h10);
    repeat (3) step();
    gap(3, nf, nc);
    chk(nc, 20);
    // Subsystem CPU clock and low current mode
    wr(PCC_ADDR, 8'h10);
    repeat (100) step();
    chk(low_power_o, 1'b1);
    rd(PCC_ADDR, 8'h30);
    gap(0, nf, nc);
    chk(nc, 40);
    wr(PCC_ADDR, 8'h00);
    repeat (100) step();
    chk(low_power_o, 1'b0);
    rd(PCC_ADDR, 8'h00);
    // Random select values read back through the model
    repeat (8) begin
      rs = xs(rs);
      wr(PSEL_ADDR, rs[7:0]);
      rd(PSEL_ADDR, sel_m);
    end
    // Second reset in mid-run, then the single mode write software should make
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    pcc_m = PCC_RESET;
    sel_m = PSEL_RESET;
    step();
    rd(PCC_ADDR, 8'h04);
    rd(PSEL_ADDR, 8'h00);
    wr(OSCILLATION_MODE_REG_ADDR, 8'h01);
    repeat (20) step();
    cnt(216, n);
    chk(n, 36);
    give_verdict();
  end
endmodule : system_clock_select_tb_top
